// *** src/srs_pkg.sv ***
// Constants, types and offsets shared by the single-register shifter
//
// What this block does
// [RQ1] Logical shifts treat the selected word plus overflow_flag as one 17-bit path.
// [RQ2] Either the main or the index working register may be the shift operand.
// [RQ3] Logical right step: bit 0 to overflow_flag, zero into bit 15.
// [RQ4] Logical left step: zero into bit 0, bit 15 to overflow_flag.
// [RQ5] Multi-position shifts repeat the one-bit step; last bit out stays in flag.
// [RQ6] Rotate right step: bit 0 to overflow_flag, old flag into bit 15.
// [RQ7] Rotate left step: bit 15 to overflow_flag, old flag into bit 0.
// [RQ8] Arithmetic left keeps bit 15, shifts bits 0-14 left, zero into bit 0.
// [RQ9] Arithmetic right keeps bit 15 and copies it into bit 14 each step.
// [RQ10] Arithmetic shifts never read or write overflow_flag; only 15 bits move.
// [RQ11] Instruction bits 12-15 select class; bit 11 zero means single-register shift.
// [RQ12] Positions shifted equal one plus the three-bit count field.
// [RQ13] First position takes one cycle, each further position a quarter cycle.
// [RQ14] The bits 12-15 value marks an instruction as a shift.
// [RQ15] A fixed table maps the operation code to operation; bit 3 picks the operand register.
package srs_pkg;

	////////////////////////////////////////////////////////////////////////////
	localparam int DATA_W = 16;
	localparam int BUS_W  = 32;
	localparam logic [15:0] RST_WORD = 16'h0000;

	// Instruction fields
	localparam int CLASS_LSB   = 12;
	localparam int CLASS_MSB   = 15;
	localparam logic [3:0] CLASS_SHIFT = 4'h1;
	localparam int FORM_BIT    = 11;
	localparam int OPC_LSB     = 4;
	localparam int OPC_MSB     = 10;
	localparam int REG_SEL_BIT = 3;
	localparam int CNT_LSB     = 0;
	localparam int CNT_MSB     = 2;

	// Operation codes held in bits 4-10; bit 3 picks the operand register
	localparam logic [6:0] OPC_LRIGHT = 7'h01;
	localparam logic [6:0] OPC_LLEFT  = 7'h02;
	localparam logic [6:0] OPC_RRIGHT = 7'h03;
	localparam logic [6:0] OPC_RLEFT  = 7'h04;
	localparam logic [6:0] OPC_ARIGHT = 7'h05;
	localparam logic [6:0] OPC_ALEFT  = 7'h06;

	// Timing: a machine cycle is four clocks, so a quarter cycle is one clock
	localparam int CLK_HZ          = 20_000_000;
	localparam int TICKS_PER_CYCLE = 4;
	localparam int CYCLE_QUARTERS  = 4;
	localparam int TICKS_PER_QTR   = TICKS_PER_CYCLE / CYCLE_QUARTERS;
	localparam logic [3:0] FIRST_STEP_TICK = 4'(TICKS_PER_CYCLE - 1);
	localparam logic [3:0] QTR_TICKS       = 4'(TICKS_PER_QTR);

	// Register byte offsets
	localparam logic [4:0] OFF_INSTR  = 5'h00;
	localparam logic [4:0] OFF_A      = 5'h04;
	localparam logic [4:0] OFF_X      = 5'h08;
	localparam logic [4:0] OFF_OV     = 5'h0C;
	localparam logic [4:0] OFF_STATUS = 5'h10;
	localparam logic [4:0] OFF_TICKS  = 5'h14;

	// Status bits
	localparam int SB_BUSY = 0;
	localparam int SB_DONE = 1;
	localparam int SB_BAD  = 2;

	////////////////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {
		OP_NONE,
		OP_LRIGHT,
		OP_LLEFT,
		OP_RRIGHT,
		OP_RLEFT,
		OP_ARIGHT,
		OP_ALEFT
	} srs_op_t;

	typedef enum logic {
		ST_IDLE,
		ST_RUN
	} srs_state_t;

endpackage : srs_pkg

// *** src/srs_step.sv ***
// One-bit shift step for every single-register operation
`timescale 1ns/1ps
module srs_step (
	// Operation
	input  wire srs_pkg::srs_op_t op,
	// Operand
	input  wire logic [15:0]      word_in,
	input  wire logic             ov_in,
	// Result
	output logic [15:0]           word_out,
	output logic                  ov_out
);

	always_comb begin
		word_out = word_in;
		ov_out   = ov_in;
		case (op)
			srs_pkg::OP_LRIGHT: begin
				ov_out   = word_in[0];                       // RQ3
				word_out = {1'b0, word_in[15:1]};             // RQ3
			end
			srs_pkg::OP_LLEFT: begin
				ov_out   = word_in[15];                      // RQ4
				word_out = {word_in[14:0], 1'b0};             // RQ4
			end
			srs_pkg::OP_RRIGHT: begin
				ov_out   = word_in[0];                       // RQ6
				word_out = {ov_in, word_in[15:1]};            // RQ6
			end
			srs_pkg::OP_RLEFT: begin
				ov_out   = word_in[15];                      // RQ7
				word_out = {word_in[14:0], ov_in};            // RQ7
			end
			srs_pkg::OP_ARIGHT: begin
				word_out = {word_in[15], word_in[15], word_in[14:1]};  // RQ9
			end
			srs_pkg::OP_ALEFT: begin
				word_out = {word_in[15], word_in[13:0], 1'b0};          // RQ8
			end
			default: begin
				word_out = word_in;
				ov_out   = ov_in;
			end
		endcase
	end

endmodule : srs_step

// *** src/srs_shifter.sv ***
// Single-register shifter with its Avalon-MM register slave
`timescale 1ns/1ps
module srs_shifter (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	// Avalon-MM slave, word addressed
	input  wire logic [2:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// Status
	output logic             busy
);

	////////////////////////////////////////////////////////////////////////////
	// Decode helpers

	function automatic logic hit(input logic [2:0] adr, input logic [4:0] off);
		hit = (adr == off[4:2]);
	endfunction : hit

	function automatic srs_pkg::srs_op_t decode_op(input logic [15:0] ins);
		logic [6:0] opc;
		opc       = ins[srs_pkg::OPC_MSB:srs_pkg::OPC_LSB];
		decode_op = srs_pkg::OP_NONE;
		if (ins[srs_pkg::CLASS_MSB:srs_pkg::CLASS_LSB] != srs_pkg::CLASS_SHIFT) begin  // RQ14
			decode_op = srs_pkg::OP_NONE;
		end else if (ins[srs_pkg::FORM_BIT]) begin                                     // RQ11
			decode_op = srs_pkg::OP_NONE;
		end else if (opc == srs_pkg::OPC_LRIGHT) begin                                 // RQ15
			decode_op = srs_pkg::OP_LRIGHT;
		end else if (opc == srs_pkg::OPC_LLEFT) begin
			decode_op = srs_pkg::OP_LLEFT;
		end else if (opc == srs_pkg::OPC_RRIGHT) begin
			decode_op = srs_pkg::OP_RRIGHT;
		end else if (opc == srs_pkg::OPC_RLEFT) begin
			decode_op = srs_pkg::OP_RLEFT;
		end else if (opc == srs_pkg::OPC_ARIGHT) begin
			decode_op = srs_pkg::OP_ARIGHT;
		end else if (opc == srs_pkg::OPC_ALEFT) begin
			decode_op = srs_pkg::OP_ALEFT;
		end
	endfunction : decode_op

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction : merge16

	////////////////////////////////////////////////////////////////////////////
	// State

	srs_pkg::srs_state_t state_q;
	srs_pkg::srs_op_t    op_q;
	logic                sel_x_q;
	logic [3:0]          steps_left_q;
	logic [3:0]          tick_q;
	logic [3:0]          next_step_q;
	logic [3:0]          last_ticks_q;
	logic [15:0]         instr_q;
	logic [15:0]         a_q;
	logic [15:0]         x_q;
	logic                overflow_flag_q;
	logic                done_q;
	logic                bad_q;
	logic                rd_ack_q;
	logic [31:0]         rdata_q;

	logic                wr_ok;
	logic                rd_ok;
	logic                blocked;
	logic                start;
	logic                step_en;
	logic                last_step;
	srs_pkg::srs_op_t    new_op;
	logic [15:0]         cur_word;
	logic [15:0]         step_word;
	logic                step_ov;
	logic [15:0]         new_ins;
	logic [31:0]         rd_word;
	logic                wr_instr;
	logic                wr_a;
	logic                wr_x;
	logic                wr_ov;
	logic                wr_status;

	////////////////////////////////////////////////////////////////////////////
	// Bus handshake
	// Reads take one wait state so that read data come from a flop.
	// Writes that would disturb a shift in flight are stalled until it ends.

	assign blocked = (state_q == srs_pkg::ST_RUN) &&
		(hit(avs_address, srs_pkg::OFF_INSTR) || hit(avs_address, srs_pkg::OFF_A) ||
		 hit(avs_address, srs_pkg::OFF_X) || hit(avs_address, srs_pkg::OFF_OV));

	assign avs_waitrequest = (avs_read && !rd_ack_q) || (avs_write && blocked);
	assign wr_ok           = avs_write && !blocked;
	assign rd_ok           = avs_read && rd_ack_q;
	assign avs_readdata    = rdata_q;
	assign busy            = (state_q == srs_pkg::ST_RUN);

	// A held read gets one wait state per word, since the acknowledge toggles
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			rd_ack_q <= 1'b0;
		end else begin
			rd_ack_q <= avs_read && !rd_ack_q;
		end
	end

	// Read word is picked from the live registers, then held in a flop
	always_comb begin
		rd_word = 32'h00000000;
		if (hit(avs_address, srs_pkg::OFF_INSTR)) begin
			rd_word = {16'h0000, instr_q};
		end else if (hit(avs_address, srs_pkg::OFF_A)) begin
			rd_word = {16'h0000, a_q};
		end else if (hit(avs_address, srs_pkg::OFF_X)) begin
			rd_word = {16'h0000, x_q};
		end else if (hit(avs_address, srs_pkg::OFF_OV)) begin
			rd_word = {31'h0, overflow_flag_q};
		end else if (hit(avs_address, srs_pkg::OFF_STATUS)) begin
			rd_word = {29'h0, bad_q, done_q, busy};
		end else if (hit(avs_address, srs_pkg::OFF_TICKS)) begin
			rd_word = {28'h0, last_ticks_q};
		end
	end

	// Loaded only in the wait cycle, so it stands until the next read
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			rdata_q <= 32'h00000000;
		end else if (avs_read && !rd_ack_q) begin
			rdata_q <= rd_word;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Write decode: one strobe per register except the read-only tick count; unmapped words raise none
	// and are dropped, so software may probe the map without side effects

	always_comb begin
		wr_instr  = 1'b0;
		wr_a      = 1'b0;
		wr_x      = 1'b0;
		wr_ov     = 1'b0;
		wr_status = 1'b0;
		if (wr_ok) begin
			if (hit(avs_address, srs_pkg::OFF_INSTR)) begin
				wr_instr = 1'b1;
			end else if (hit(avs_address, srs_pkg::OFF_A)) begin
				wr_a = 1'b1;
			end else if (hit(avs_address, srs_pkg::OFF_X)) begin
				wr_x = 1'b1;
			end else if (hit(avs_address, srs_pkg::OFF_OV)) begin
				wr_ov = 1'b1;
			end else if (hit(avs_address, srs_pkg::OFF_STATUS)) begin
				wr_status = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Instruction intake

	// Byte lanes merge first so a partial write decodes the word it will store
	assign new_ins = merge16(instr_q, avs_writedata, avs_byteenable);
	assign new_op  = decode_op(new_ins);
	assign start   = wr_instr && (new_op != srs_pkg::OP_NONE);

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			instr_q <= srs_pkg::RST_WORD;
		end else if (wr_instr) begin
			instr_q <= new_ins;
		end
	end

	// Operation is latched once per instruction
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			op_q <= srs_pkg::OP_NONE;
		end else if (start) begin
			op_q <= new_op;
		end
	end

	// Operand choice steers the datapath for the whole shift
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			sel_x_q <= 1'b0;
		end else if (start) begin
			sel_x_q <= new_ins[srs_pkg::REG_SEL_BIT];                             // RQ2
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			state_q <= srs_pkg::ST_IDLE;
		end else begin
			case (state_q)
				srs_pkg::ST_IDLE: begin
					if (start) begin
						state_q <= srs_pkg::ST_RUN;
					end
				end
				srs_pkg::ST_RUN: begin
					if (last_step) begin
						state_q <= srs_pkg::ST_IDLE;
					end
				end
				default: begin
					state_q <= srs_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// First position lands at the end of a full cycle, later ones each quarter
	assign step_en   = (state_q == srs_pkg::ST_RUN) && (tick_q == next_step_q);  // RQ13
	assign last_step = step_en && (steps_left_q == 4'h1);                         // RQ5

	// Clocks since the start edge; it only runs while a shift is in flight
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			tick_q <= 4'h0;
		end else if (start) begin
			tick_q <= 4'h0;
		end else if (state_q == srs_pkg::ST_RUN) begin
			tick_q <= tick_q + 4'h1;
		end
	end

	// Tick at which the next position lands
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			next_step_q <= srs_pkg::FIRST_STEP_TICK;
		end else if (start) begin
			next_step_q <= srs_pkg::FIRST_STEP_TICK;                                // RQ13
		end else if (step_en) begin
			next_step_q <= next_step_q + srs_pkg::QTR_TICKS;                        // RQ13
		end
	end

	// Positions still to go, loaded as one plus the count field
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			steps_left_q <= 4'h0;
		end else if (start) begin
			steps_left_q <= {1'b0, new_ins[srs_pkg::CNT_MSB:srs_pkg::CNT_LSB]} + 4'h1; // RQ12
		end else if (step_en) begin
			steps_left_q <= steps_left_q - 4'h1;                                    // RQ5
		end
	end

	// Clocks taken by the last shift, for software to inspect
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			last_ticks_q <= 4'h0;
		end else if (last_step) begin
			last_ticks_q <= tick_q + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Datapath

	assign cur_word = sel_x_q ? x_q : a_q;                                       // RQ2

	// One stepper reused each position keeps area small at the cost of time
	srs_step u_step (
		.op       (op_q),
		.word_in  (cur_word),
		.ov_in    (overflow_flag_q),                                              // RQ1
		.word_out (step_word),
		.ov_out   (step_ov)
	);

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			a_q <= srs_pkg::RST_WORD;
		end else if (step_en && !sel_x_q) begin
			a_q <= step_word;                                                     // RQ5
		end else if (wr_a) begin
			a_q <= merge16(a_q, avs_writedata, avs_byteenable);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			x_q <= srs_pkg::RST_WORD;
		end else if (step_en && sel_x_q) begin
			x_q <= step_word;                                                     // RQ5
		end else if (wr_x) begin
			x_q <= merge16(x_q, avs_writedata, avs_byteenable);
		end
	end

	// Arithmetic steps pass the flag through untouched
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			overflow_flag_q <= 1'b0;
		end else if (step_en && (op_q != srs_pkg::OP_ARIGHT) &&
			(op_q != srs_pkg::OP_ALEFT)) begin                                     // RQ10
			overflow_flag_q <= step_ov;                                           // RQ1
		end else if (wr_ov && avs_byteenable[0]) begin
			overflow_flag_q <= avs_writedata[0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sticky status; a set in the same cycle as a clear wins

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			done_q <= 1'b0;
		end else if (last_step) begin
			done_q <= 1'b1;
		end else if (wr_status && avs_byteenable[0] && avs_writedata[srs_pkg::SB_DONE]) begin
			done_q <= 1'b0;
		end
	end

	// Instructions outside the shift class or table are dropped and flagged
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			bad_q <= 1'b0;
		end else if (wr_ok && hit(avs_address, srs_pkg::OFF_INSTR) &&
			(new_op == srs_pkg::OP_NONE)) begin                                    // RQ11
			bad_q <= 1'b1;
		end else if (wr_status && avs_byteenable[0] && avs_writedata[srs_pkg::SB_BAD]) begin
			bad_q <= 1'b0;
		end
	end

endmodule : srs_shifter

// *** bench/srs_shifter_props.sv ***
// Port checker for the single-register shifter
`timescale 1ns/1ps
module srs_shifter_props (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        resetn,
	// Register bus
	input wire logic [2:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// Status
	input wire logic        busy
);
	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	logic       wr_ok;
	logic       ins_ok;
	logic       start_w;
	logic [2:0] k_q;
	logic [3:0] cnt_q;
	assign wr_ok   = avs_write && !avs_waitrequest && avs_address == 3'h0;
	assign ins_ok  = avs_writedata[15:11] == 5'h02 && avs_writedata[10:4] inside {[7'h01:7'h06]};
	assign start_w = wr_ok && ins_ok;
	// Count kept from the accepted instruction; busy length counted beside it
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			k_q   <= 3'h0;
			cnt_q <= 4'h0;
		end else begin
			k_q   <= wr_ok ? avs_writedata[2:0] : k_q;
			cnt_q <= busy ? cnt_q + 4'h1 : 4'h0;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	property p_rd_wait; $rose(avs_read) |-> avs_waitrequest; endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read without wait state");
	property p_rd_ans; avs_read && avs_waitrequest |=> !avs_waitrequest; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read wait too long");
	property p_start; start_w |=> busy; endproperty
	a_start: assert property (p_start) else $error("shift did not start");
	property p_refuse; wr_ok && !ins_ok |=> !busy; endproperty
	a_refuse: assert property (p_refuse) else $error("bad word started a shift");
	property p_len; $fell(busy) |-> cnt_q == 4'h4 + {1'h0, k_q}; endproperty
	a_len: assert property (p_len) else $error("shift length wrong");
	property p_stall; busy && avs_write && avs_address < 3'h4 |-> avs_waitrequest; endproperty
	a_stall: assert property (p_stall) else $error("write taken while busy");
	property p_nostall; avs_write && (!busy || avs_address > 3'h3) |-> !avs_waitrequest; endproperty
	a_nostall: assert property (p_nostall) else $error("write stalled needlessly");
	property p_cause; $rose(busy) |-> $past(start_w); endproperty
	a_cause: assert property (p_cause) else $error("busy without instruction");
	property p_bound; busy |-> ##[1:11] !busy; endproperty
	a_bound: assert property (p_bound) else $error("shift overran eight steps");
	c_start: cover property (start_w);
	c_stall: cover property (busy && avs_write && avs_waitrequest);
	c_bad: cover property (wr_ok && !ins_ok);
endmodule : srs_shifter_props
bind srs_shifter srs_shifter_props i_srs_shifter_props (.ref_clk(ref_clk), .resetn(resetn),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .busy(busy));

// *** bench/srs_host.sv ***
// Decoder and register-file side model, master of the shifter's bus
`timescale 1ns/1ps
module srs_host (
	// Clock
	input wire logic        ref_clk,
	// Register bus
	output logic [2:0]      avs_address,
	output logic            avs_read,
	output logic            avs_write,
	output logic [31:0]     avs_writedata,
	output logic [3:0]      avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest
);
	initial begin
		avs_address    = 3'h0;
		avs_read       = 1'h0;
		avs_write      = 1'h0;
		avs_writedata  = 32'h0;
		avs_byteenable = 4'hF;
	end
	// Request stands until the rising edge that samples waitrequest low
	task automatic hold_req(output logic [31:0] d);
		do begin
			@(posedge ref_clk);
		end while (avs_waitrequest !== 1'h0);
		d = avs_readdata;
	endtask : hold_req
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		logic [31:0] nc;
		@(posedge ref_clk);
		avs_address   <= a;
		avs_writedata <= {16'h0, d};
		avs_write     <= 1'h1;
		hold_req(nc);
		avs_write     <= 1'h0;
		avs_writedata <= ~{16'h0, d};
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_read    <= 1'h1;
		hold_req(d);
		avs_read    <= 1'h0;
	endtask : rd
endmodule : srs_host

// *** bench/srs_shifter_tb.sv ***
// Self-checking bench for the single-register shifter
`timescale 1ns/1ps
module srs_shifter_tb;
	typedef struct packed {
		logic [6:0]  opc;
		logic        sel;
		logic [2:0]  k;
		logic [15:0] word;
		logic        ov;
		logic [15:0] exp_word;
		logic        exp_ov;
	} srs_row_t;
	logic        ref_clk, resetn, busy, avs_read, avs_write, avs_waitrequest;
	logic [2:0]  avs_address;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, rdat;
	logic [15:0] bad [4];
	srs_row_t    rows [6];
	int          n_fail, checks, cyc;
	srs_shifter i_srs_shifter (.ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .busy(busy));
	srs_host i_srs_host (.ref_clk(ref_clk), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	always #25 ref_clk = ~ref_clk;
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rchk(input logic [2:0] a, input logic [31:0] exp);
		i_srs_host.rd(a, rdat);
		chk(rdat, exp);
	endtask : rchk
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (busy !== 1'h0 && n < 20);
		chk({31'h0, busy}, 32'h0);
	endtask : wait_idle
	task automatic run_row(input srs_row_t r);
		logic [2:0] tgt;
		tgt = r.sel ? 3'h2 : 3'h1;
		i_srs_host.wr(tgt, r.word);
		i_srs_host.wr(3'h3 - tgt, 16'h5A5A);
		i_srs_host.wr(3'h3, {15'h0, r.ov});
		i_srs_host.wr(3'h0, {4'h1, 1'h0, r.opc, r.sel, r.k});
		wait_idle();
		rchk(tgt, {16'h0, r.exp_word});
		rchk(3'h3 - tgt, 32'h5A5A);
		rchk(3'h3, {31'h0, r.exp_ov});
		rchk(3'h5, 32'h4 + r.k);
		rchk(3'h4, 32'h2);
	endtask : run_row
	task automatic close_out();
		if (n_fail == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : close_out
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			$display("ERROR %0t run did not finish", $time);
			close_out();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'h0;
		resetn  = 1'h0;
		rows[0] = '{srs_pkg::OPC_LRIGHT, 1'h0, 3'h0, 16'h8001, 1'h0, 16'h4000, 1'h1};
		rows[1] = '{srs_pkg::OPC_LLEFT, 1'h1, 3'h7, 16'h8181, 1'h0, 16'h8100, 1'h1};
		rows[2] = '{srs_pkg::OPC_RRIGHT, 1'h0, 3'h1, 16'h0003, 1'h0, 16'h8000, 1'h1};
		rows[3] = '{srs_pkg::OPC_RLEFT, 1'h1, 3'h2, 16'hC000, 1'h1, 16'h0007, 1'h0};
		rows[4] = '{srs_pkg::OPC_ARIGHT, 1'h0, 3'h3, 16'h8010, 1'h1, 16'hF801, 1'h1};
		rows[5] = '{srs_pkg::OPC_ALEFT, 1'h1, 3'h7, 16'hC081, 1'h0, 16'h8100, 1'h0};
		bad     = '{16'h2010, 16'h1810, 16'h1001, 16'h1070};
		repeat (3) @(posedge ref_clk);
		resetn <= 1'h1;
		foreach (rows[i]) run_row(rows[i]);
		// Rejected words must not disturb the operand
		i_srs_host.wr(3'h4, 16'h0006);
		foreach (bad[i]) begin
			i_srs_host.wr(3'h1, 16'h1234);
			i_srs_host.wr(3'h0, bad[i]);
			@(negedge ref_clk);
			chk({31'h0, busy}, 32'h0);
			rchk(3'h4, 32'h4);
			rchk(3'h1, 32'h1234);
			i_srs_host.wr(3'h4, 16'h0004);
		end
		rchk(3'h4, 32'h0);
		// Operand write while running must wait for the last step
		i_srs_host.wr(3'h1, 16'h0001);
		i_srs_host.wr(3'h3, 16'h0000);
		i_srs_host.wr(3'h0, {4'h1, 1'h0, srs_pkg::OPC_LLEFT, 1'h0, 3'h7});
		rchk(3'h4, 32'h1);
		i_srs_host.wr(3'h1, 16'hBEEF);
		rchk(3'h1, 32'hBEEF);
		rchk(3'h3, 32'h0);
		rchk(3'h5, 32'hB);
		i_srs_host.wr(3'h7, 16'hFFFF);
		rchk(3'h6, 32'h0);
		rchk(3'h7, 32'h0);
		// Reset in the middle of a shift
		i_srs_host.wr(3'h0, {4'h1, 1'h0, srs_pkg::OPC_RLEFT, 1'h1, 3'h7});
		@(posedge ref_clk);
		resetn <= 1'h0;
		repeat (3) @(posedge ref_clk);
		resetn <= 1'h1;
		for (int a = 1; a < 6; a++) rchk(3'(a), 32'h0);
		close_out();
	end
endmodule : srs_shifter_tb
